/* File: ptm_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types of the pulse timer module channel block
// Assumes: APB register slave, one byte register per aligned 32-bit word
// Notes:   Offsets are word indices; the byte address is four times the index
//////////////////////////////////////////////////////////////////////////////
package ptm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Structure sizes
	localparam int NUM_CH = 2; // Channels in this timer

	////////////////////////////////////////////////////////////////////////////
	// Register word indices (byte address = index * 4)
	localparam logic [5:0] IDX_TIMER_CTL = 6'h00; // timer_control_register
	localparam logic [5:0] IDX_CNT_HIGH = 6'h01; // counter_high
	localparam logic [5:0] IDX_CNT_LOW = 6'h02; // counter_low
	localparam logic [5:0] IDX_MOD_HIGH = 6'h03; // modulus_high
	localparam logic [5:0] IDX_MOD_LOW = 6'h04; // modulus_low
	localparam logic [5:0] IDX_CH_BASE = 6'h05; // Channel 0 control
	localparam logic [5:0] IDX_CH_STRIDE = 6'h03; // Words per channel
	localparam logic [5:0] IDX_CH_CTL = 6'h00; // channel_control_register
	localparam logic [5:0] IDX_CH_VAL_HIGH = 6'h01; // channel_value_high
	localparam logic [5:0] IDX_CH_VAL_LOW = 6'h02; // channel_value_low

	////////////////////////////////////////////////////////////////////////////
	// Timer control fields
	localparam int TC_FLAG_BIT = 7; // counter_overflow_flag
	localparam int TC_IRQEN_BIT = 6; // overflow_irq_enable
	localparam int TC_CENTER_BIT = 5; // center_pwm_select
	localparam int TC_RUN_BIT = 3; // Counter runs when set

	////////////////////////////////////////////////////////////////////////////
	// Channel control fields
	localparam int CC_FLAG_BIT = 7; // channel_event_flag
	localparam int CC_IRQEN_BIT = 6; // channel_irq_enable
	localparam int CC_MODEB_BIT = 5; // Mode select high
	localparam int CC_MODEA_BIT = 4; // Mode select low
	localparam int CC_ELSB_BIT = 3; // edge_level_select_b
	localparam int CC_ELSA_BIT = 2; // edge_level_select_a

	////////////////////////////////////////////////////////////////////////////
	// Values
	localparam logic [15:0] CNT_RESET = 16'h0000; // Counter after reset
	localparam logic [15:0] MOD_FREE = 16'h0000; // Modulus meaning free run
	localparam logic [15:0] CNT_MAX = 16'hffff; // Free running terminal count
	localparam logic [15:0] VAL_ZERO = 16'h0000; // Zero duty value
	localparam int SIGN_BIT = 15; // Negative channel value

	////////////////////////////////////////////////////////////////////////////
	// Channel operating modes
	typedef enum logic [3:0] {
		MODE_CAPTURE = 4'b0001,
		MODE_COMPARE = 4'b0010,
		MODE_EDGE = 4'b0100,
		MODE_CENTER = 4'b1000
	} ptm_mode_t;

	// Per channel state
	typedef struct packed {
		logic irq_en; // channel_irq_enable
		logic flag; // channel_event_flag
		logic arm; // Flag read while set
		logic [1:0] mode_sel; // Mode select bits
		logic [1:0] els; // edge_level_select_b:a
		logic [15:0] val; // Active channel value
		logic [15:0] vbuf; // Write buffer
		logic got_high; // High byte buffered
		logic got_low; // Low byte buffered
		logic latched; // Read coherency latch held
		logic latch_high_first; // Which byte opened the latch
		logic [15:0] latch; // Latched capture value
		logic [2:0] sync; // Capture input synchroniser
		logic out; // Channel pin level
	} ptm_ch_t;

	// Whole block state
	typedef struct packed {
		logic [15:0] cnt; // Main counter
		logic down; // Counting down
		logic run; // Counter enabled
		logic center_aligned_pwm; // center_pwm_select
		logic overflow_irq_enable; // overflow_irq_enable
		logic counter_overflow_flag; // counter_overflow_flag
		logic tof_arm; // Overflow flag read while set
		logic [15:0] mod; // Active modulus
		logic [15:0] mod_buf; // Modulus write buffer
		logic mod_got_high; // High byte buffered
		logic mod_got_low; // Low byte buffered
		ptm_ch_t [NUM_CH-1:0] ch; // Channels
		logic [31:0] prdata; // Read data
		logic perr; // Unmapped address seen
	} ptm_state_t;

	localparam ptm_state_t STATE_RESET = '0; // Everything cleared

endpackage : ptm_pkg

/* File: ptm_timer.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Counter and channel logic of the pulse timer module: capture,
//          compare, edge and center PWM, buffered updates, flags, interrupts
// Assumes: One clock; counter advances each clock while running
// Notes:   Read side effects act in the APB setup cycle, writes in access
//////////////////////////////////////////////////////////////////////////////
//
// Chosen here: the APB register port and the address map.
module ptm_timer
	import ptm_pkg::*;
(
	input wire logic pclk, // Timer and bus clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped word
	input wire logic [NUM_CH-1:0] capture_in, // Channel pins as inputs
	output logic [NUM_CH-1:0] channel_out, // Channel pin levels
	output logic [NUM_CH-1:0] channel_oe, // Channel pin drive enables
	output logic irq_overflow, // Overflow interrupt request
	output logic [NUM_CH-1:0] irq_channel // Channel interrupt requests
);

	//////////////////////////////////////////////////////////////////////////
	// State
	ptm_state_t r_reg; // Registered state
	ptm_state_t r_next; // Next state
	logic [NUM_CH-1:0] ch_event; // Channel event this cycle

	// Mode of a channel from the select bits
	function automatic ptm_mode_t mode_of(input logic center_aligned_pwm, input logic [1:0] ms);
		ptm_mode_t m;
		m = MODE_CAPTURE;
		if (center_aligned_pwm) begin
			m = MODE_CENTER;
		end else if (ms[1]) begin
			m = MODE_EDGE;
		end else if (ms[0]) begin
			m = MODE_COMPARE;
		end
		return m;
	endfunction : mode_of

	//////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic setup; // APB setup cycle
		logic wr; // Write completes now
		logic rd_setup; // Read being set up
		logic [5:0] idx; // Word index
		logic ovf; // Up count wrap
		logic turn; // Up/down turn at modulus
		logic [15:0] term; // Terminal count
		logic [5:0] base; // Channel word base
		logic match; // Counter equals value
		logic edge_hit; // Selected input edge
		logic rise; // Synchronised rising edge
		logic fall; // Synchronised falling edge
		logic both; // Both value bytes buffered
		logic mapped; // Address hits a register
		logic [7:0] rbyte; // Byte being read
		ptm_mode_t mode; // Current channel mode
		setup = psel & ~penable;
		wr = psel & penable & pwrite;
		rd_setup = setup & ~pwrite;
		idx = paddr[7:2];
		ovf = 1'b0;
		turn = 1'b0;
		base = IDX_CH_BASE;
		match = 1'b0;
		edge_hit = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		both = 1'b0;
		mapped = 1'b0;
		rbyte = 8'h00;
		mode = MODE_CAPTURE;
		ch_event = '0;
		r_next = r_reg;

		// Main counter, free run when modulus is zero outside center mode
		term = (r_reg.mod == MOD_FREE) ? CNT_MAX : r_reg.mod;
		if (r_reg.run) begin
			if (!r_reg.center_aligned_pwm) begin
				r_next.down = 1'b0;
				if (r_reg.cnt == term) begin
					r_next.cnt = CNT_RESET;
					ovf = 1'b1;
				end else begin
					r_next.cnt = r_reg.cnt + 16'h0001;
				end
			end else if (!r_reg.down) begin
				// Up leg ends at the modulus
				if (r_reg.cnt == r_reg.mod) begin
					r_next.down = 1'b1;
					r_next.cnt = r_reg.cnt - 16'h0001;
					turn = 1'b1;
				end else begin
					r_next.cnt = r_reg.cnt + 16'h0001;
				end
			end else begin
				// Down leg turns back up at zero
				if (r_reg.cnt == CNT_RESET) begin
					r_next.down = 1'b0;
					r_next.cnt = r_reg.cnt + 16'h0001;
				end else begin
					r_next.cnt = r_reg.cnt - 16'h0001;
				end
			end
		end
		if (ovf || turn) begin
			r_next.counter_overflow_flag = 1'b1;
			r_next.tof_arm = 1'b0;
		end

		// Modulus buffer; waits for the turn when centered
		if (r_reg.mod_got_high && r_reg.mod_got_low && (!r_reg.center_aligned_pwm || turn)) begin
			r_next.mod = r_reg.mod_buf;
			r_next.mod_got_high = 1'b0;
			r_next.mod_got_low = 1'b0;
		end

		// Channels
		for (int i = 0; i < NUM_CH; i++) begin
			mode = mode_of(r_reg.center_aligned_pwm, r_reg.ch[i].mode_sel);
			// Only the second and third stages are compared
			r_next.ch[i].sync = {r_reg.ch[i].sync[1:0], capture_in[i]};
			rise = r_reg.ch[i].sync[1] & ~r_reg.ch[i].sync[2];
			fall = ~r_reg.ch[i].sync[1] & r_reg.ch[i].sync[2];
			match = r_reg.run && (r_reg.cnt == r_reg.ch[i].val);
			both = r_reg.ch[i].got_high & r_reg.ch[i].got_low;
			case (mode)
				MODE_CAPTURE: begin
					case (r_reg.ch[i].els)
						2'b01: edge_hit = rise;
						2'b10: edge_hit = fall;
						2'b11: edge_hit = rise | fall;
						default: edge_hit = 1'b0;
					endcase
					if (both) begin
						r_next.ch[i].val = r_reg.ch[i].vbuf;
						r_next.ch[i].got_high = 1'b0;
						r_next.ch[i].got_low = 1'b0;
					end
					if (edge_hit) begin
						r_next.ch[i].val = r_reg.cnt;
						ch_event[i] = 1'b1;
					end
				end
				MODE_COMPARE: begin
					if (both) begin
						r_next.ch[i].val = r_reg.ch[i].vbuf;
						r_next.ch[i].got_high = 1'b0;
						r_next.ch[i].got_low = 1'b0;
					end
					if (match) begin
						ch_event[i] = 1'b1;
						case (r_reg.ch[i].els)
							2'b01: r_next.ch[i].out = ~r_reg.ch[i].out;
							2'b10: r_next.ch[i].out = 1'b0;
							2'b11: r_next.ch[i].out = 1'b1;
							default: r_next.ch[i].out = r_reg.ch[i].out;
						endcase
					end
				end
				MODE_EDGE: begin
					// Period start drives active level, match wins so zero gives none
					if (r_reg.run && r_reg.cnt == CNT_RESET) begin
						r_next.ch[i].out = ~r_reg.ch[i].els[0];
					end
					if (match) begin
						r_next.ch[i].out = r_reg.ch[i].els[0];
						ch_event[i] = 1'b1;
					end
					if (both && r_reg.cnt == CNT_RESET) begin
						r_next.ch[i].val = r_reg.ch[i].vbuf;
						r_next.ch[i].got_high = 1'b0;
						r_next.ch[i].got_low = 1'b0;
					end
				end
				MODE_CENTER: begin
					if (r_reg.ch[i].val == VAL_ZERO || r_reg.ch[i].val[SIGN_BIT]) begin
						r_next.ch[i].out = r_reg.ch[i].els[0];
					end else if (match) begin
						r_next.ch[i].out = r_reg.down ? ~r_reg.ch[i].els[0] : r_reg.ch[i].els[0];
						ch_event[i] = 1'b1;
					end else if (turn && r_reg.ch[i].val > r_reg.mod) begin
						r_next.ch[i].out = ~r_reg.ch[i].els[0];
					end
					if (both && turn) begin
						r_next.ch[i].val = r_reg.ch[i].vbuf;
						r_next.ch[i].got_high = 1'b0;
						r_next.ch[i].got_low = 1'b0;
					end
				end
				default: begin
					ch_event[i] = 1'b0;
				end
			endcase
			if (ch_event[i]) begin
				r_next.ch[i].flag = 1'b1;
				r_next.ch[i].arm = 1'b0;
			end
		end

		// Read decode and read side effects in the setup cycle
		if (idx == IDX_TIMER_CTL) begin
			mapped = 1'b1;
			rbyte = 8'h00;
			rbyte[TC_FLAG_BIT] = r_reg.counter_overflow_flag;
			rbyte[TC_IRQEN_BIT] = r_reg.overflow_irq_enable;
			rbyte[TC_CENTER_BIT] = r_reg.center_aligned_pwm;
			rbyte[TC_RUN_BIT] = r_reg.run;
			if (rd_setup && r_reg.counter_overflow_flag && !(ovf || turn)) begin
				r_next.tof_arm = 1'b1;
			end
		end else if (idx == IDX_CNT_HIGH) begin
			mapped = 1'b1;
			rbyte = r_reg.cnt[15:8];
		end else if (idx == IDX_CNT_LOW) begin
			mapped = 1'b1;
			rbyte = r_reg.cnt[7:0];
		end else if (idx == IDX_MOD_HIGH) begin
			mapped = 1'b1;
			rbyte = r_reg.mod[15:8];
		end else if (idx == IDX_MOD_LOW) begin
			mapped = 1'b1;
			rbyte = r_reg.mod[7:0];
		end
		for (int i = 0; i < NUM_CH; i++) begin
			base = 6'(IDX_CH_BASE + i * IDX_CH_STRIDE);
			mode = mode_of(r_reg.center_aligned_pwm, r_reg.ch[i].mode_sel);
			if (idx == base + IDX_CH_CTL) begin
				mapped = 1'b1;
				rbyte = 8'h00;
				rbyte[CC_FLAG_BIT] = r_reg.ch[i].flag;
				rbyte[CC_IRQEN_BIT] = r_reg.ch[i].irq_en;
				rbyte[CC_MODEB_BIT] = r_reg.ch[i].mode_sel[1];
				rbyte[CC_MODEA_BIT] = r_reg.ch[i].mode_sel[0];
				rbyte[CC_ELSB_BIT] = r_reg.ch[i].els[1];
				rbyte[CC_ELSA_BIT] = r_reg.ch[i].els[0];
				if (rd_setup && r_reg.ch[i].flag && !ch_event[i]) begin
					r_next.ch[i].arm = 1'b1;
				end
			end else if (idx == base + IDX_CH_VAL_HIGH || idx == base + IDX_CH_VAL_LOW) begin
				mapped = 1'b1;
				if (idx == base + IDX_CH_VAL_HIGH) begin
					rbyte = r_reg.ch[i].latched ? r_reg.ch[i].latch[15:8] : r_reg.ch[i].val[15:8];
				end else begin
					rbyte = r_reg.ch[i].latched ? r_reg.ch[i].latch[7:0] : r_reg.ch[i].val[7:0];
				end
				// Capture reads stay coherent until the other byte is read
				if (rd_setup && mode == MODE_CAPTURE) begin
					if (!r_reg.ch[i].latched) begin
						r_next.ch[i].latched = 1'b1;
						r_next.ch[i].latch = r_reg.ch[i].val;
						r_next.ch[i].latch_high_first = (idx == base + IDX_CH_VAL_HIGH);
					end else if (r_reg.ch[i].latch_high_first != (idx == base + IDX_CH_VAL_HIGH)) begin
						r_next.ch[i].latched = 1'b0;
					end
				end
			end
		end
		if (setup) begin
			r_next.prdata = {24'h000000, rbyte};
			r_next.perr = ~mapped;
		end

		// Writes in the access cycle
		if (wr && idx == IDX_TIMER_CTL) begin
			r_next.overflow_irq_enable = pwdata[TC_IRQEN_BIT];
			r_next.center_aligned_pwm = pwdata[TC_CENTER_BIT];
			r_next.run = pwdata[TC_RUN_BIT];
			r_next.mod_got_high = 1'b0;
			r_next.mod_got_low = 1'b0;
			r_next.tof_arm = 1'b0;
			// A new overflow in the same cycle keeps the flag
			if (r_reg.tof_arm && !pwdata[TC_FLAG_BIT] && !(ovf || turn)) begin
				r_next.counter_overflow_flag = 1'b0;
			end
		end
		if (wr && (idx == IDX_CNT_HIGH || idx == IDX_CNT_LOW)) begin
			// Any counter write restarts the count upward
			r_next.cnt = CNT_RESET;
			r_next.down = 1'b0;
		end
		if (wr && idx == IDX_MOD_HIGH) begin
			r_next.mod_buf[15:8] = pwdata[7:0];
			r_next.mod_got_high = 1'b1;
		end
		if (wr && idx == IDX_MOD_LOW) begin
			r_next.mod_buf[7:0] = pwdata[7:0];
			r_next.mod_got_low = 1'b1;
		end
		for (int i = 0; i < NUM_CH; i++) begin
			base = 6'(IDX_CH_BASE + i * IDX_CH_STRIDE);
			if (wr && idx == base + IDX_CH_CTL) begin
				r_next.ch[i].irq_en = pwdata[CC_IRQEN_BIT];
				r_next.ch[i].mode_sel = {pwdata[CC_MODEB_BIT], pwdata[CC_MODEA_BIT]};
				r_next.ch[i].els = {pwdata[CC_ELSB_BIT], pwdata[CC_ELSA_BIT]};
				r_next.ch[i].got_high = 1'b0;
				r_next.ch[i].got_low = 1'b0;
				r_next.ch[i].latched = 1'b0;
				r_next.ch[i].arm = 1'b0;
				if (r_reg.ch[i].arm && !pwdata[CC_FLAG_BIT] && !ch_event[i]) begin
					r_next.ch[i].flag = 1'b0;
				end
			end
			if (wr && idx == base + IDX_CH_VAL_HIGH) begin
				r_next.ch[i].vbuf[15:8] = pwdata[7:0];
				r_next.ch[i].got_high = 1'b1;
			end
			if (wr && idx == base + IDX_CH_VAL_LOW) begin
				r_next.ch[i].vbuf[7:0] = pwdata[7:0];
				r_next.ch[i].got_low = 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= STATE_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// APB answer: zero wait states, data prepared in setup
	assign pready = 1'b1;
	assign prdata = r_reg.prdata;
	assign pslverr = psel & penable & r_reg.perr;
	assign irq_overflow = r_reg.counter_overflow_flag & r_reg.overflow_irq_enable;

	//////////////////////////////////////////////////////////////////////////
	// Per channel pins and interrupt levels
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		// Pin driven only by compare or PWM with a level choice
		assign channel_out[g] = r_reg.ch[g].out;
		assign channel_oe[g] = (r_reg.center_aligned_pwm | r_reg.ch[g].mode_sel[1] | r_reg.ch[g].mode_sel[0])
			& (r_reg.ch[g].els != 2'b00);
		assign irq_channel[g] = r_reg.ch[g].flag & r_reg.ch[g].irq_en;
	end

endmodule : ptm_timer

/* File: ptm_pin_model.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Far side of the channel pins: an external source and a load
// Assumes: Source level moves away from the timer's sampling edge
// Notes:   Wire level resolves from the timer's drive enable
module ptm_pin_model
	import ptm_pkg::*;
(
	input wire logic pclk, // Timer clock, only to offset changes
	input wire logic [NUM_CH-1:0] drive_lvl, // Requested source level
	input wire logic [NUM_CH-1:0] channel_out, // Timer pin level
	input wire logic [NUM_CH-1:0] channel_oe, // Timer drive enables
	output logic [NUM_CH-1:0] pin // Resolved wire level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [NUM_CH-1:0] src_reg; // Source level on the wire

	// Falling edge keeps source changes half a cycle away from the timer's sampling edge
	always @(negedge pclk) begin
		src_reg <= drive_lvl;
	end

	// Timer wins where it drives, else the source sets the level
	assign pin = (channel_oe & channel_out) | (~channel_oe & src_reg);
endmodule : ptm_pin_model

/* File: ptm_timer_monitor.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Port checker of the pulse timer channel block
// Assumes: Zero wait state APB slave, eleven mapped words
// Notes:   Bound to the timer at the foot of this file
module ptm_timer_monitor
	import ptm_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic [NUM_CH-1:0] capture_in, // Pin inputs
	input wire logic [NUM_CH-1:0] channel_out, // Pin levels
	input wire logic [NUM_CH-1:0] channel_oe, // Pin enables
	input wire logic irq_overflow, // Overflow request
	input wire logic [NUM_CH-1:0] irq_channel // Channel requests
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc_wr; // Write access phase
	assign acc_wr = psel && penable && pwrite;

	//////////////////////////////////////////
	// Requests fall only through a control write
	property p_ovf_hold;
		irq_overflow && !(acc_wr && paddr == 8'h00) |=> irq_overflow;
	endproperty
	a_ovf_hold: assert property (p_ovf_hold)
		else $error("overflow request dropped without control write");
	property p_ch0_hold;
		irq_channel[0] && !(acc_wr && paddr == 8'h14) |=> irq_channel[0];
	endproperty
	a_ch0_hold: assert property (p_ch0_hold)
		else $error("channel 0 request dropped without control write");
	property p_ch1_hold;
		irq_channel[1] && !(acc_wr && paddr == 8'h20) |=> irq_channel[1];
	endproperty
	a_ch1_hold: assert property (p_ch1_hold)
		else $error("channel 1 request dropped without control write");

	//////////////////////////////////////////
	// Bus answers
	property p_ready;
		psel && penable |-> pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("access not completed at once");
	property p_unmapped;
		psel && penable && paddr[7:2] > 6'h0a |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");
	property p_mapped;
		psel && penable && paddr[7:2] <= 6'h0a |-> !pslverr;
	endproperty
	a_mapped: assert property (p_mapped)
		else $error("mapped access refused");
	property p_upper_zero;
		prdata[31:8] == 24'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("read data upper bits set");

	// Pin drive only follows a configuration write
	property p_oe_cause;
		$changed(channel_oe) |-> $past(acc_wr && (paddr == 8'h00 || paddr == 8'h14 || paddr == 8'h20));
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("pin enable changed without configuration write");
endmodule : ptm_timer_monitor

bind ptm_timer ptm_timer_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.capture_in(capture_in), .channel_out(channel_out), .channel_oe(channel_oe),
	.irq_overflow(irq_overflow), .irq_channel(irq_channel));

/* File: testbench.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench of the pulse timer channel block
// Assumes: Modulus 0x20, so edge period 33 and center period 64
// Notes:   Pin levels are read from the far-side model's wire
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ptm_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [31:0] r; logic e;} ptm_row_t;
	typedef struct {logic c; logic [15:0] v; int h;} ptm_duty_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_ov, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [NUM_CH-1:0] pin, chan_out, chan_oe, irq_ch, drive_lvl;
	int n_errors = 0; // Mismatches
	int num_checks = 0; // Comparisons
	int hi; // Counted cycles
	// Write then read back: address, data, read value, refusal
	ptm_row_t rows [7] = '{'{8'h0c, 8'h00, 32'h0, 1'b0}, '{8'h10, 8'h20, 32'h20, 1'b0},
		'{8'h2c, 8'h55, 32'h0, 1'b1}, '{8'hfc, 8'h55, 32'h0, 1'b1}, '{8'h20, 8'h54, 32'h54, 1'b0},
		'{8'h24, 8'h00, 32'h0, 1'b0}, '{8'h28, 8'h10, 32'h10, 1'b0}};
	// Mode, channel value, high cycles over two periods
	ptm_duty_t duties [6] = '{'{1'b0, 16'h0010, 32}, '{1'b0, 16'h0000, 0}, '{1'b0, 16'h0030, 66},
		'{1'b1, 16'h0010, 64}, '{1'b1, 16'h8000, 0}, '{1'b1, 16'h0030, 128}};

	ptm_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capture_in(pin), .channel_out(chan_out), .channel_oe(chan_oe), .irq_overflow(irq_ov),
		.irq_channel(irq_ch));
	ptm_pin_model pins_u (.pclk(pclk), .drive_lvl(drive_lvl), .channel_out(chan_out),
		.channel_oe(chan_oe), .pin(pin));

	//////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Read the flag while set, then write it back as zero
	task automatic clr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b0, a, 8'h00);
		apb(1'b1, a, d);
	endtask : clr

	// Bounded wait for a request; negative channel means overflow
	task automatic wait_irq(input int ch);
		repeat (80) begin
			@(posedge pclk);
			if ((ch < 0 ? irq_ov : irq_ch[ch]) === 1'b1) break;
		end
	endtask : wait_irq

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test

	// Watchdog: runs far beyond the roughly 1800 cycles the tests need
	initial begin
		#(25ns * 20000);
		n_errors++;
		$display("[ERR] watchdog expected done seen timeout");
		finish_test();
	end

	//////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		drive_lvl = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check("reset outputs", {irq_ov, irq_ch, chan_oe, chan_out, pready}, 32'h1);
		check("reset read data", prdata, 32'h0);
		// Ordinary accesses, unmapped words among them
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			check("write err", er, rows[i].e);
			apb(1'b0, rows[i].a, 8'h00);
			check("read data", rdv, rows[i].r);
			check("read err", er, rows[i].e);
		end
		$display("test registers done");
		// Compare toggle on channel 1 at count 0x10
		apb(1'b1, 8'h08, 8'h00);
		apb(1'b1, 8'h00, 8'h08);
		wait_irq(1);
		check("compare request", irq_ch[1], 1'b1);
		check("compare pin", pin[1], 1'b1);
		hi = 0;
		do begin
			@(posedge pclk);
			hi++;
		end while (pin[1] === 1'b1 && hi < 100);
		check("toggle period", hi, 33);
		clr(8'h20, 8'h54);
		check("flag read", rdv, 32'hd4);
		@(negedge pclk);
		check("flag cleared", irq_ch[1], 1'b0);
		// A write without the read must leave the flag set
		wait_irq(1);
		apb(1'b1, 8'h20, 8'h54);
		@(negedge pclk);
		check("flag kept", irq_ch[1], 1'b1);
		$display("test compare done");
		// Overflow request and its clearing
		apb(1'b1, 8'h00, 8'h48);
		wait_irq(-1);
		check("overflow request", irq_ov, 1'b1);
		clr(8'h00, 8'h48);
		check("overflow read", rdv, 32'hc8);
		@(negedge pclk);
		check("overflow cleared", irq_ov, 1'b0);
		$display("test overflow done");
		// Capture edge select: none, rising, falling, either
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, 8'h14, {4'h4, k[1:0], 2'b00});
			clr(8'h14, {4'h4, k[1:0], 2'b00});
			drive_lvl[0] <= 1'b1;
			repeat (8) @(posedge pclk);
			check("rise capture", irq_ch[0], k[0]);
			clr(8'h14, {4'h4, k[1:0], 2'b00});
			drive_lvl[0] <= 1'b0;
			repeat (8) @(posedge pclk);
			check("fall capture", irq_ch[0], k[1]);
			clr(8'h14, {4'h4, k[1:0], 2'b00});
		end
		$display("test capture done");
		// Counter stopped, zeroed, run for exactly three clocks, stopped again
		apb(1'b1, 8'h00, 8'h00);
		apb(1'b1, 8'h08, 8'h00);
		apb(1'b1, 8'h00, 8'h08);
		apb(1'b1, 8'h00, 8'h00);
		// Rising edge on channel 0 (either edge selected) captures the count 3
		drive_lvl[0] <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1'b0, 8'h1c, 8'h00);
		check("capture low", rdv, 32'h3);
		apb(1'b0, 8'h18, 8'h00);
		check("capture high", rdv, 32'h0);
		$display("test capture value done");
		// Edge and center duty over two full periods
		foreach (duties[i]) begin
			apb(1'b1, 8'h00, duties[i].c ? 8'h28 : 8'h08);
			apb(1'b1, 8'h20, 8'h68);
			apb(1'b1, 8'h24, duties[i].v[15:8]);
			apb(1'b1, 8'h28, duties[i].v[7:0]);
			repeat (130) @(posedge pclk);
			hi = 0;
			repeat (duties[i].c ? 128 : 66) begin
				@(posedge pclk);
				if (pin[1] === 1'b1) hi++;
			end
			check("duty", hi, duties[i].h);
		end
		$display("test duty done");
		// Second reset in mid-run
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check("mid reset", {irq_ov, irq_ch, chan_oe, chan_out}, 32'h0);
		check("mid reset data", prdata, 32'h0);
		presetn <= 1'b1;
		// First transfer right after release; modulus back at its reset value
		apb(1'b0, 8'h10, 8'h00);
		check("modulus after reset", rdv, 32'h0);
		check("read err after reset", er, 1'b0);
		$display("test reset done");
		finish_test();
	end
endmodule : testbench
